// *** rtl/cbl_pkg.sv ***
// cbl_pkg: constants and carriers for the channel 2 / bias / lead-detect register slice
// assumes a 32-bit APB slave on a single 50 MHz clock
package cbl_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // bus geometry
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 32;
  localparam int unsigned REG_W  = 8;

  // register indices; byte address is four times the index
  localparam logic [ADDR_W-1:0] IDX_CHANNEL2_CONFIG  = 8'h05;
  localparam logic [ADDR_W-1:0] IDX_BIAS_SOURCE_SEL  = 8'h06;
  localparam logic [ADDR_W-1:0] IDX_ELECTRODE_DETECT = 8'h07;
  localparam logic [1:0]        ADDR_ALIGN_ZERO      = 2'h0;

  // reset values
  localparam logic [REG_W-1:0] RST_CHANNEL2_CONFIG  = 8'h00;
  localparam logic [REG_W-1:0] RST_BIAS_SOURCE_SEL  = 8'h00;
  localparam logic [REG_W-1:0] RST_ELECTRODE_DETECT = 8'h00;

  // writable mask of the lead-detect byte; bits 7:6 read zero
  localparam logic [REG_W-1:0] MASK_ELECTRODE_DETECT = 8'h3F;

  ////////////////////////////////////////////////////////////////////////////
  // field positions
  localparam int unsigned POS_CH2_POWER_DOWN  = 7;
  localparam int unsigned POS_CH2_GAIN_LO     = 4;
  localparam int unsigned POS_CH2_SOURCE_LO   = 0;
  localparam int unsigned POS_CHOP_LO         = 6;
  localparam int unsigned POS_BIAS_BUFFER     = 5;
  localparam int unsigned POS_BIAS_LEAD_CHECK = 4;
  localparam int unsigned POS_BIAS_SOURCES_LO = 0;
  localparam int unsigned POS_REVERSE_LO      = 4;
  localparam int unsigned POS_DETECT_LO       = 0;

  ////////////////////////////////////////////////////////////////////////////
  // gain codes
  localparam logic [2:0] GAIN_6  = 3'h0;
  localparam logic [2:0] GAIN_1  = 3'h1;
  localparam logic [2:0] GAIN_2  = 3'h2;
  localparam logic [2:0] GAIN_3  = 3'h3;
  localparam logic [2:0] GAIN_4  = 3'h4;
  localparam logic [2:0] GAIN_8  = 3'h5;
  localparam logic [2:0] GAIN_12 = 3'h6;

  // input source codes
  localparam int unsigned SRC_COUNT          = 10;
  localparam logic [3:0] SRC_NORMAL          = 4'h0;
  localparam logic [3:0] SRC_SHORTED         = 4'h1;
  localparam logic [3:0] SRC_BIAS_MEASURE    = 4'h2;
  localparam logic [3:0] SRC_HALF_SUPPLY     = 4'h3;
  localparam logic [3:0] SRC_TEMPERATURE     = 4'h4;
  localparam logic [3:0] SRC_TEST_SIGNAL     = 4'h5;
  localparam logic [3:0] SRC_BIAS_TIE_POS    = 4'h6;
  localparam logic [3:0] SRC_BIAS_TIE_NEG    = 4'h7;
  localparam logic [3:0] SRC_BIAS_TIE_BOTH   = 4'h8;
  localparam logic [3:0] SRC_THIRD_PAIR      = 4'h9;

  // chop codes and last counts of the modulator tick divider, one less than each divisor
  localparam logic [1:0] CHOP_DIV16    = 2'h0;
  localparam logic [1:0] CHOP_RESERVED = 2'h1;
  localparam logic [1:0] CHOP_DIV2     = 2'h2;
  localparam logic [1:0] CHOP_DIV4     = 2'h3;
  localparam logic [3:0] CHOP_LAST16   = 4'hF;
  localparam logic [3:0] CHOP_LAST2    = 4'h1;
  localparam logic [3:0] CHOP_LAST4    = 4'h3;

  ////////////////////////////////////////////////////////////////////////////
  // carriers
  typedef struct packed {
    logic              write;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } cbl_apb_req_t;

  typedef struct packed {
    logic       powerDown;
    logic [2:0] gain;
    logic [3:0] source;
  } cbl_ch2_cfg_t;

  typedef struct packed {
    logic [1:0] chop;
    logic       bufferPower;
    logic       leadCheck;
    logic [3:0] sources;
  } cbl_bias_cfg_t;

  typedef struct packed {
    logic [1:0] zero;
    logic [1:0] reverse;
    logic [3:0] detect;
  } cbl_detect_cfg_t;

endpackage : cbl_pkg

// *** rtl/cbl_apb_port.sv ***
// cbl_apb_port: APB handshake, one wait state per access
// assumes master holds the request stable until pready is sampled high
`timescale 1ns/1ps
module cbl_apb_port (
  input  wire logic                      mclk,
  input  wire logic                      reset,
  input  wire logic                      psel,
  input  wire logic                      penable,
  input  wire logic                      pwrite,
  input  wire logic [cbl_pkg::ADDR_W-1:0] paddr,
  input  wire logic [cbl_pkg::DATA_W-1:0] pwdata,
  output logic                           pready,
  output cbl_pkg::cbl_apb_req_t          req,
  output logic                           loadAnswer,
  output logic                           commit
);

  ////////////////////////////////////////////////////////////////////////////
  // request view
  always_comb begin
    req.write = pwrite;
    req.addr  = paddr;
    req.wdata = pwdata;
  end

  // first access cycle loads the answer, second completes
  assign loadAnswer = psel & penable & ~pready;
  assign commit     = psel & penable & pready;

  always_ff @(posedge mclk) begin
    if (reset) begin
      pready <= 1'b0;
    end else begin
      pready <= loadAnswer;
    end
  end

endmodule : cbl_apb_port

// *** rtl/cbl_regs.sv ***
// cbl_regs: channel 2 config, bias source select and lead-detect select registers
// assumes APB master on mclk; modTick is a one-cycle modulator-rate enable on mclk
//
// Functional notes
// - channel 2 byte: power-down, gain, input source
// - power-down resets 0; 1 powers down
// - gain codes 6,1,2,3,4,8,12; 111 undefined
// - source codes 0000 to 1001 decoded
// - source codes 0110 to 1001; 1010 to 1111 reserved
// - chop field: div16, div2, div4; 01 reserved
// - bias buffer bit, resets powered down
// - bias lead check enable, resets off
// - four electrode bias-source bits, reset 0
// - detect byte: zeros, reverse flags, selects
// - reverse and detect bits reset 0
//
// Decided for this implementation: register access over APB.
`timescale 1ns/1ps
module cbl_regs (
  input  wire logic                           mclk,
  input  wire logic                           reset,
  input  wire logic                           psel,
  input  wire logic                           penable,
  input  wire logic                           pwrite,
  input  wire logic [cbl_pkg::ADDR_W-1:0]     paddr,
  input  wire logic [cbl_pkg::DATA_W-1:0]     pwdata,
  output logic      [cbl_pkg::DATA_W-1:0]     prdata,
  output logic                                pready,
  output logic                                pslverr,
  input  wire logic                           modTick,
  output logic                                ch2_power_down,
  output logic      [2:0]                     ch2_gain_field,
  output logic      [3:0]                     ch2_input_source,
  output logic      [3:0]                     ch2GainValue,
  output logic                                ch2GainUndefined,
  output logic      [cbl_pkg::SRC_COUNT-1:0]  ch2SourceOneHot,
  output logic                                ch2SourceReserved,
  output logic                                chopTick,
  output logic                                chopReserved,
  output logic                                bias_buffer_power,
  output logic                                bias_lead_check_enable,
  output logic                                bias_from_ch2_neg,
  output logic                                bias_from_ch2_pos,
  output logic                                bias_from_ch1_neg,
  output logic                                bias_from_ch1_pos,
  output logic                                ch2_current_reverse,
  output logic                                ch1_current_reverse,
  output logic                                detect_ch2_neg,
  output logic                                detect_ch2_pos,
  output logic                                detect_ch1_neg,
  output logic                                detect_ch1_pos
);

  ////////////////////////////////////////////////////////////////////////////
  // storage
  cbl_pkg::cbl_ch2_cfg_t    channel2_config;
  cbl_pkg::cbl_bias_cfg_t   bias_drive_source_select;
  cbl_pkg::cbl_detect_cfg_t electrode_detect_select;

  cbl_pkg::cbl_apb_req_t    req;
  logic                     loadAnswer;
  logic                     commit;
  logic                     aligned;
  logic [cbl_pkg::ADDR_W-1:0] regIndex;
  logic                     hitCh2;
  logic                     hitBias;
  logic                     hitDetect;
  logic                     hitAny;
  logic [cbl_pkg::REG_W-1:0] wrByte;
  logic [cbl_pkg::REG_W-1:0] next_readByte;
  logic [3:0]               next_gainValue;
  logic [3:0]               chopCount;
  logic [3:0]               chopLast;
  logic [1:0]               chopSeen;

  ////////////////////////////////////////////////////////////////////////////
  // bus handshake
  cbl_apb_port u_port (
    .mclk       (mclk),
    .reset      (reset),
    .psel       (psel),
    .penable    (penable),
    .pwrite     (pwrite),
    .paddr      (paddr),
    .pwdata     (pwdata),
    .pready     (pready),
    .req        (req),
    .loadAnswer (loadAnswer),
    .commit     (commit)
  );

  ////////////////////////////////////////////////////////////////////////////
  // address decode
  always_comb begin
    aligned   = (req.addr[1:0] == cbl_pkg::ADDR_ALIGN_ZERO);
    regIndex  = {2'h0, req.addr[cbl_pkg::ADDR_W-1:2]};
    hitCh2    = aligned && (regIndex == cbl_pkg::IDX_CHANNEL2_CONFIG);
    hitBias   = aligned && (regIndex == cbl_pkg::IDX_BIAS_SOURCE_SEL);
    hitDetect = aligned && (regIndex == cbl_pkg::IDX_ELECTRODE_DETECT);
    hitAny    = hitCh2 | hitBias | hitDetect;
    wrByte    = req.wdata[cbl_pkg::REG_W-1:0];
  end

  ////////////////////////////////////////////////////////////////////////////
  // channel 2 configuration
  always_ff @(posedge mclk) begin
    if (reset) begin
      channel2_config <= cbl_pkg::RST_CHANNEL2_CONFIG;
    end else if (commit && req.write && hitCh2) begin
      channel2_config.powerDown <= wrByte[cbl_pkg::POS_CH2_POWER_DOWN];
      channel2_config.gain      <= wrByte[cbl_pkg::POS_CH2_GAIN_LO +: 3];
      channel2_config.source    <= wrByte[cbl_pkg::POS_CH2_SOURCE_LO +: 4];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // bias source selection
  always_ff @(posedge mclk) begin
    if (reset) begin
      bias_drive_source_select <= cbl_pkg::RST_BIAS_SOURCE_SEL;
    end else if (commit && req.write && hitBias) begin
      bias_drive_source_select.chop        <= wrByte[cbl_pkg::POS_CHOP_LO +: 2];
      bias_drive_source_select.bufferPower <= wrByte[cbl_pkg::POS_BIAS_BUFFER];
      bias_drive_source_select.leadCheck   <= wrByte[cbl_pkg::POS_BIAS_LEAD_CHECK];
      bias_drive_source_select.sources     <= wrByte[cbl_pkg::POS_BIAS_SOURCES_LO +: 4];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // lead-detect selection
  always_ff @(posedge mclk) begin
    if (reset) begin
      electrode_detect_select <= cbl_pkg::RST_ELECTRODE_DETECT;
    end else if (commit && req.write && hitDetect) begin
      electrode_detect_select.zero    <= 2'h0;
      electrode_detect_select.reverse <= wrByte[cbl_pkg::POS_REVERSE_LO +: 2];
      electrode_detect_select.detect  <= wrByte[cbl_pkg::POS_DETECT_LO +: 4];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read answer
  always_comb begin
    next_readByte = 8'h00;
    if (hitCh2) begin
      next_readByte = channel2_config;
    end else if (hitBias) begin
      next_readByte = bias_drive_source_select;
    end else if (hitDetect) begin
      next_readByte = electrode_detect_select & cbl_pkg::MASK_ELECTRODE_DETECT;
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      prdata  <= 32'h00000000;
      pslverr <= 1'b0;
    end else if (loadAnswer) begin
      prdata  <= req.write ? 32'h00000000 : {24'h000000, next_readByte};
      pslverr <= ~hitAny;
    end else if (commit) begin
      prdata  <= 32'h00000000;
      pslverr <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // gain decode
  always_comb begin
    case (channel2_config.gain)
      cbl_pkg::GAIN_6:  next_gainValue = 4'h6;
      cbl_pkg::GAIN_1:  next_gainValue = 4'h1;
      cbl_pkg::GAIN_2:  next_gainValue = 4'h2;
      cbl_pkg::GAIN_3:  next_gainValue = 4'h3;
      cbl_pkg::GAIN_4:  next_gainValue = 4'h4;
      cbl_pkg::GAIN_8:  next_gainValue = 4'h8;
      cbl_pkg::GAIN_12: next_gainValue = 4'hC;
      default:          next_gainValue = 4'h0;
    endcase
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      ch2GainValue     <= 4'h6;
      ch2GainUndefined <= 1'b0;
    end else begin
      ch2GainValue     <= next_gainValue;
      ch2GainUndefined <= (next_gainValue == 4'h0);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // input source decode, one flop per source
  genvar s;
  generate
    for (s = 0; s < cbl_pkg::SRC_COUNT; s++) begin : g_src
      always_ff @(posedge mclk) begin
        if (reset) begin
          ch2SourceOneHot[s] <= (s == 0);
        end else begin
          ch2SourceOneHot[s] <= (channel2_config.source == 4'(s));
        end
      end
    end
  endgenerate

  always_ff @(posedge mclk) begin
    if (reset) begin
      ch2SourceReserved <= 1'b0;
    end else begin
      ch2SourceReserved <= (channel2_config.source > cbl_pkg::SRC_THIRD_PAIR);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // chop enable divider from the modulator tick
  always_comb begin
    case (bias_drive_source_select.chop)
      cbl_pkg::CHOP_DIV16: chopLast = cbl_pkg::CHOP_LAST16;
      cbl_pkg::CHOP_DIV2:  chopLast = cbl_pkg::CHOP_LAST2;
      cbl_pkg::CHOP_DIV4:  chopLast = cbl_pkg::CHOP_LAST4;
      default:             chopLast = 4'h0;
    endcase
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      chopCount    <= 4'h0;
      chopSeen     <= cbl_pkg::CHOP_DIV16;
      chopTick     <= 1'b0;
      chopReserved <= 1'b0;
    end else begin
      chopSeen     <= bias_drive_source_select.chop;
      chopReserved <= (bias_drive_source_select.chop == cbl_pkg::CHOP_RESERVED);
      chopTick     <= 1'b0;
      if (chopSeen != bias_drive_source_select.chop) begin
        chopCount <= 4'h0;
      end else if (modTick && (bias_drive_source_select.chop != cbl_pkg::CHOP_RESERVED)) begin
        if (chopCount >= chopLast) begin
          chopCount <= 4'h0;
          chopTick  <= 1'b1;
        end else begin
          chopCount <= chopCount + 4'h1;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // control outputs to the analog side
  always_ff @(posedge mclk) begin
    if (reset) begin
      ch2_power_down   <= 1'b0;
      ch2_gain_field   <= 3'h0;
      ch2_input_source <= 4'h0;
    end else begin
      ch2_power_down   <= channel2_config.powerDown;
      ch2_gain_field   <= channel2_config.gain;
      ch2_input_source <= channel2_config.source;
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      bias_buffer_power      <= 1'b0;
      bias_lead_check_enable <= 1'b0;
      bias_from_ch2_neg      <= 1'b0;
      bias_from_ch2_pos      <= 1'b0;
      bias_from_ch1_neg      <= 1'b0;
      bias_from_ch1_pos      <= 1'b0;
    end else begin
      bias_buffer_power      <= bias_drive_source_select.bufferPower;
      bias_lead_check_enable <= bias_drive_source_select.leadCheck;
      bias_from_ch2_neg      <= bias_drive_source_select.sources[3];
      bias_from_ch2_pos      <= bias_drive_source_select.sources[2];
      bias_from_ch1_neg      <= bias_drive_source_select.sources[1];
      bias_from_ch1_pos      <= bias_drive_source_select.sources[0];
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      ch2_current_reverse <= 1'b0;
      ch1_current_reverse <= 1'b0;
      detect_ch2_neg      <= 1'b0;
      detect_ch2_pos      <= 1'b0;
      detect_ch1_neg      <= 1'b0;
      detect_ch1_pos      <= 1'b0;
    end else begin
      ch2_current_reverse <= electrode_detect_select.reverse[1];
      ch1_current_reverse <= electrode_detect_select.reverse[0];
      detect_ch2_neg      <= electrode_detect_select.detect[3];
      detect_ch2_pos      <= electrode_detect_select.detect[2];
      detect_ch1_neg      <= electrode_detect_select.detect[1];
      detect_ch1_pos      <= electrode_detect_select.detect[0];
    end
  end

endmodule : cbl_regs

// *** verif/cbl_regs_props.sv ***
// cbl_regs_props: port-level checks of the register slice
// assumes binding into cbl_regs; one clock, sync reset
`timescale 1ns/1ps
module cbl_regs_props (
  input wire logic        mclk,
  input wire logic        reset,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        ch2_power_down,
  input wire logic [2:0]  ch2_gain_field,
  input wire logic [3:0]  ch2_input_source,
  input wire logic [3:0]  ch2GainValue,
  input wire logic        ch2GainUndefined,
  input wire logic [9:0]  ch2SourceOneHot,
  input wire logic        ch2SourceReserved,
  input wire logic        chopTick,
  input wire logic        chopReserved,
  input wire logic        bias_buffer_power,
  input wire logic        bias_lead_check_enable,
  input wire logic        bias_from_ch2_neg,
  input wire logic        bias_from_ch2_pos,
  input wire logic        bias_from_ch1_neg,
  input wire logic        bias_from_ch1_pos,
  input wire logic        ch2_current_reverse,
  input wire logic        ch1_current_reverse,
  input wire logic        detect_ch2_neg,
  input wire logic        detect_ch2_pos,
  input wire logic        detect_ch1_neg,
  input wire logic        detect_ch1_pos
);
  localparam logic [7:0] A_CH2  = cbl_pkg::IDX_CHANNEL2_CONFIG << 2;
  localparam logic [7:0] A_BIAS = cbl_pkg::IDX_BIAS_SOURCE_SEL << 2;
  localparam logic [7:0] A_DET  = cbl_pkg::IDX_ELECTRODE_DETECT << 2;
  wire logic  okWr = pready && !pslverr && pwrite;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (reset);
  ////////////////////////////////////////////////////////////////////////////
  // numeric gain per code; decoded outputs launch with the field copies
  function automatic logic [3:0] gain_of(input logic [2:0] c);
    case (c)
      3'h0: return 4'h6;
      3'h5: return 4'h8;
      3'h6: return 4'hC;
      3'h7: return 4'h0;
      default: return {1'b0, c};
    endcase
  endfunction : gain_of
  ////////////////////////////////////////////////////////////////////////////
  a_ready_one_wait: assert property (psel && !penable |=> !pready ##1 pready)
    else $error("pready not in second access cycle");
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  a_err_data_zero: assert property (pready && pslverr |-> prdata == 32'h0)
    else $error("error reply carries data");
  a_upper_zero: assert property (pready |-> prdata[31:8] == 24'h0)
    else $error("upper read bits not zero");
  a_detect_top_zero: assert property (pready && !pwrite && paddr == A_DET
    |-> prdata[7:6] == 2'h0)
    else $error("detect byte top bits not zero");
  a_ch2_write: assert property (okWr && paddr == A_CH2 |-> ##2
    {ch2_power_down, ch2_gain_field, ch2_input_source} == $past(pwdata[7:0], 2))
    else $error("channel 2 fields differ from write");
  a_bias_write: assert property (okWr && paddr == A_BIAS |-> ##2
    {bias_buffer_power, bias_lead_check_enable, bias_from_ch2_neg, bias_from_ch2_pos,
     bias_from_ch1_neg, bias_from_ch1_pos} == $past(pwdata[5:0], 2))
    else $error("bias fields differ from write");
  a_detect_write: assert property (okWr && paddr == A_DET |-> ##2
    {ch2_current_reverse, ch1_current_reverse, detect_ch2_neg, detect_ch2_pos,
     detect_ch1_neg, detect_ch1_pos} == $past(pwdata[5:0], 2))
    else $error("detect fields differ from write");
  a_gain_decode: assert property (ch2GainValue == gain_of(ch2_gain_field)
    && ch2GainUndefined == (ch2_gain_field == 3'h7))
    else $error("gain decode wrong");
  a_source_decode: assert property (ch2SourceReserved == (ch2_input_source >= 4'hA)
    && ch2SourceOneHot == ((ch2_input_source < 4'hA)
    ? (10'h001 << ch2_input_source) : 10'h000))
    else $error("source decode wrong");
  a_chop_quiet: assert property (chopReserved |-> !chopTick)
    else $error("chop tick on reserved code");
  a_chop_pulse: assert property (chopTick |=> !chopTick)
    else $error("chop tick too long");
  a_reset_values: assert property ($fell(reset) |-> ch2GainValue == 4'h6
    && ch2SourceOneHot == 10'h001 && {ch2_power_down, bias_buffer_power,
    bias_lead_check_enable, ch2_current_reverse, detect_ch1_pos} == 5'h0)
    else $error("reset values wrong");
endmodule : cbl_regs_props

bind cbl_regs cbl_regs_props u_props (.*);

// *** verif/cbl_host_model.sv ***
// cbl_host_model: host side of the register bus, an APB master with bounded waits
// assumes tasks are entered just after a rising edge of mclk
`timescale 1ns/1ps
module cbl_host_model (
  input  wire logic        mclk,
  output logic             psel,
  output logic             penable,
  output logic             pwrite,
  output logic [7:0]       paddr,
  output logic [31:0]      pwdata,
  input  wire logic [31:0] prdata,
  input  wire logic        pready,
  input  wire logic        pslverr
);
  // power down only with shorted inputs
  localparam logic [7:0] PD_SHORTED = {1'b1, 3'h0, cbl_pkg::SRC_SHORTED};
  // status is never read here; only select bits are trusted
  initial begin
    psel    = 1'b0;
    penable = 1'b0;
    pwrite  = 1'b0;
    paddr   = 8'h00;
    pwdata  = 32'h0;
  end
  ////////////////////////////////////////////////////////////////////////////
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q, output logic e, output bit ok);
    int n;
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge mclk);
    penable <= 1'b1;
    ok = 1'b0;
    for (n = 0; n < 16 && !ok; n++) begin
      @(posedge mclk);
      ok = (pready === 1'b1);
    end
    q = prdata;
    e = pslverr;
  endtask : xfer
  // released lines show a changed value
  task automatic idle();
    psel    <= 1'b0;
    penable <= 1'b0;
    paddr   <= ~paddr;
    pwdata  <= ~pwdata;
    @(posedge mclk);
  endtask : idle
endmodule : cbl_host_model

// *** verif/channel2_bias_leadoff_config_regs_tb.sv ***
// channel2_bias_leadoff_config_regs_tb: register access, decode and chop tests
// assumes cbl_regs with its checker bound in; 50 MHz clock
`timescale 1ns/1ps
module channel2_bias_leadoff_config_regs_tb;
  logic        mclk, reset, modTick, psel, penable, pwrite, pready, pslverr;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata;
  logic        ch2_power_down, ch2GainUndefined, ch2SourceReserved, chopTick, chopReserved;
  logic [2:0]  ch2_gain_field;
  logic [3:0]  ch2_input_source, ch2GainValue;
  logic [9:0]  ch2SourceOneHot;
  logic        bias_buffer_power, bias_lead_check_enable, bias_from_ch2_neg;
  logic        bias_from_ch2_pos, bias_from_ch1_neg, bias_from_ch1_pos;
  logic        ch2_current_reverse, ch1_current_reverse, detect_ch2_neg;
  logic        detect_ch2_pos, detect_ch1_neg, detect_ch1_pos;
  int          errorCnt = 0;
  int          totalChecks = 0;
  localparam logic [7:0] A_CH2  = cbl_pkg::IDX_CHANNEL2_CONFIG << 2;
  localparam logic [7:0] A_BIAS = cbl_pkg::IDX_BIAS_SOURCE_SEL << 2;
  localparam logic [7:0] A_DET  = cbl_pkg::IDX_ELECTRODE_DETECT << 2;
  logic [3:0]  gainTab [8] = '{4'h6, 4'h1, 4'h2, 4'h3, 4'h4, 4'h8, 4'hC, 4'h0};
  int          tickTab [4] = '{2, 0, 16, 8};
  cbl_regs DUT (.*);
  cbl_host_model host (.*);
  initial begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end
  ////////////////////////////////////////////////////////////////////////////
  task automatic conclude();
    $display("checks %0d errors %0d", totalChecks, errorCnt);
    if (errorCnt == 0 && totalChecks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : conclude
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    totalChecks++;
    if (seen !== exp) begin
      errorCnt++;
      $display("unexpected %s: expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic rw(input logic w, input logic [7:0] a, input logic [31:0] d,
                    input logic [31:0] exp, input logic err);
    logic [31:0] q;
    logic        e;
    bit          ok;
    host.xfer(w, a, d, q, e, ok);
    if (!ok) begin
      errorCnt++;
      conclude();
    end
    if (!w) chk("read data", q, exp);
    chk("pslverr", {31'h0, e}, {31'h0, err});
  endtask : rw
  task automatic settle();
    host.idle();
    repeat (4) @(posedge mclk);
  endtask : settle
  task automatic check_reset();
    rw(1'b0, A_CH2, 32'h0, 32'h0, 1'b0);
    rw(1'b0, A_BIAS, 32'h0, 32'h0, 1'b0);
    rw(1'b0, A_DET, 32'h0, 32'h0, 1'b0);
    settle();
    chk("gain value", {28'h0, ch2GainValue}, 32'h6);
    chk("source onehot", {22'h0, ch2SourceOneHot}, 32'h1);
  endtask : check_reset
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    int n;
    logic [7:0] d;
    reset = 1'b1;
    modTick = 1'b0;
    repeat (5) @(posedge mclk);
    reset <= 1'b0;
    @(posedge mclk);
    check_reset();
    for (int g = 0; g < 8; g++) begin
      d = {1'b0, g[2:0], 4'h0};
      rw(1'b1, A_CH2, {24'h0, d}, 32'h0, 1'b0);
      rw(1'b0, A_CH2, 32'h0, {24'h0, d}, 1'b0);
      settle();
      chk("gain value", {28'h0, ch2GainValue}, {28'h0, gainTab[g]});
      chk("gain undefined", {31'h0, ch2GainUndefined}, {31'h0, g == 7});
    end
    for (int s = 0; s < 16; s++) begin
      d = {4'h1, s[3:0]};
      rw(1'b1, A_CH2, {24'h0, d}, 32'h0, 1'b0);
      rw(1'b0, A_CH2, 32'h0, {24'h0, d}, 1'b0);
      settle();
      chk("source onehot", {22'h0, ch2SourceOneHot}, (s < 10) ? 32'h1 << s : 32'h0);
      chk("source reserved", {31'h0, ch2SourceReserved}, {31'h0, s > 9});
    end
    rw(1'b1, A_CH2, {24'h0, host.PD_SHORTED}, 32'h0, 1'b0);
    settle();
    chk("power down", {31'h0, ch2_power_down}, 32'h1);
    for (int c = 0; c < 4; c++) begin
      d = {c[1:0], 6'h2A ^ {6{c[0]}}};
      rw(1'b1, A_BIAS, {24'hFFFFFF, d}, 32'h0, 1'b0);
      rw(1'b0, A_BIAS, 32'h0, {24'h0, d}, 1'b0);
      modTick <= 1'b1;
      settle();
      n = 0;
      repeat (32) begin
        @(posedge mclk);
        if (chopTick === 1'b1) n++;
      end
      modTick <= 1'b0;
      chk("chop ticks", n, tickTab[c]);
      chk("chop reserved", {31'h0, chopReserved}, {31'h0, c == 1});
      chk("bias fields", {26'h0, bias_buffer_power, bias_lead_check_enable,
        bias_from_ch2_neg, bias_from_ch2_pos, bias_from_ch1_neg, bias_from_ch1_pos},
        {26'h0, d[5:0]});
    end
    rw(1'b1, A_DET, 32'hFFFFFFEA, 32'h0, 1'b0);
    rw(1'b0, A_DET, 32'h0, 32'h2A, 1'b0);
    settle();
    chk("detect fields", {26'h0, ch2_current_reverse, ch1_current_reverse,
      detect_ch2_neg, detect_ch2_pos, detect_ch1_neg, detect_ch1_pos}, 32'h2A);
    rw(1'b0, 8'h20, 32'h0, 32'h0, 1'b1);
    rw(1'b0, 8'h19, 32'h0, 32'h0, 1'b1);
    rw(1'b1, 8'h15, 32'h55, 32'h0, 1'b1);
    rw(1'b0, A_CH2, 32'h0, {24'h0, host.PD_SHORTED}, 1'b0);
    settle();
    reset <= 1'b1;
    repeat (5) @(posedge mclk);
    reset <= 1'b0;
    @(posedge mclk);
    check_reset();
    conclude();
  end
  initial begin
    #2000000;
    errorCnt++;
    conclude();
  end
endmodule : channel2_bias_leadoff_config_regs_tb
